// file: hdl/tx_status_compose.v
// Builds one status word from the transmitter's end-of-frame result
`default_nettype none
module tx_status_compose (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        resetn_i,
  // Frame result
  input  wire        done_i,
  input  wire [15:0] tag_i,
  input  wire        lost_carrier_i,
  input  wire        no_carrier_i,
  input  wire        late_col_i,
  input  wire        excess_col_i,
  input  wire [3:0]  col_count_i,
  input  wire        excess_defer_i,
  input  wire        deferred_i,
  input  wire        defchk_en_i,
  // Status word
  output reg  [31:0] word_o,
  output reg         valid_o
);
`include "tx_status_map.vh"
  reg [31:0] w;
  reg        xdef;

  // Word assembly; reserved bits stay zero
  always @* begin
    w = 32'h0000_0000;
    xdef = excess_defer_i & defchk_en_i;
    w[31:`B_TAG_LO] = tag_i;
    w[`ST_LOC]  = lost_carrier_i;
    w[`ST_NOC]  = no_carrier_i;
    w[`ST_LATE] = late_col_i;
    w[`ST_EXC]  = excess_col_i;
    w[`ST_CC_LO+3:`ST_CC_LO] = col_count_i;
    w[`ST_XDEF] = xdef;
    w[`ST_DEF]  = deferred_i;
    w[`ST_ES]   = w[11] | w[10] | w[9] | w[8] | w[2] | w[1];
  end

  // One word per finished frame, one cycle later
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      word_o  <= 32'h0000_0000;
      valid_o <= 1'b0;
    end else begin
      valid_o <= done_i;
      if (done_i) begin
        word_o <= w;
      end
    end
  end
endmodule // tx_status_compose
`default_nettype wire

// file: hdl/tx_status_fifo_and_control.v
// Transmit status FIFO, data FIFO accounting and stop control
`default_nettype none
module tx_status_fifo_and_control (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        resetn_i,
  // AHB-Lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  // Toward the data FIFO storage
  output wire        txd_wr_o,
  output wire [31:0] txd_wdata_o,
  // Transmitter handshake
  output wire        tx_go_o,
  input  wire        mac_start_i,
  input  wire        mac_pop_i,
  input  wire        mac_done_i,
  input  wire [15:0] mac_tag_i,
  input  wire        mac_lost_carrier_i,
  input  wire        mac_no_carrier_i,
  input  wire        mac_late_col_i,
  input  wire        mac_excess_col_i,
  input  wire [3:0]  mac_col_count_i,
  input  wire        mac_excess_defer_i,
  input  wire        mac_deferred_i,
  // Events
  output wire        transmit_stopped_event_o,
  output wire        transmit_error_flag_o
);
`include "tx_status_map.vh"
  localparam [1:0] D_CMDA = 2'b00;
  localparam [1:0] D_CMDB = 2'b01;
  localparam [1:0] D_DATA = 2'b10;

  // ==========================================================
  // Helpers
  function [10:0] dw_ceil;
    input [12:0] bytes;
    reg   [12:0] t;
    begin
      t = bytes + 13'h0003;
      dw_ceil = t[12:2];
    end
  endfunction

  // ==========================================================
  // State
  reg        ph_ff;
  reg        ph_wr_ff;
  reg [7:0]  ph_addr_ff;
  reg        hready_ff;
  reg [31:0] hrdata_ff;
  reg        hresp_ff;
  reg        cfg_on_ff;
  reg        cfg_stop_ff;
  reg        cfg_sao_ff;
  reg        cfg_defchk_ff;
  reg        purge_sts_ff;
  reg        purge_dat_ff;
  reg        err_ff;
  reg        stopped_ff;
  reg        stop_pulse_ff;
  reg        tx_go_ff;
  reg        in_flight_ff;
  reg        sts_lost_ff;
  reg [7:0]  pending_ff;
  reg [11:0] dused_ff;
  reg        txd_wr_ff;
  reg [31:0] txd_wdata_ff;
  reg [1:0]  dstate_ff;
  reg [10:0] idx_ff;
  reg [31:0] cmda_ff;
  reg [31:0] cmdb_ff;
  reg [15:0] bsum_ff;
  reg [1:0]  nxt_dstate;
  reg [10:0] nxt_idx;
  reg [15:0] nxt_bsum;
  reg        store_w;
  reg        b_err;
  reg        len_err;
  reg        pkt_done;
  reg [12:0] rmask;

  wire        acc;
  wire        wr_go;
  wire        rd_go;
  wire        dwr;
  wire [31:0] sts_word;
  wire        sts_valid;
  wire [31:0] sts_head;
  wire [4:0]  sts_cnt;
  wire        sts_full;
  wire        sts_empty;
  wire        sts_pop;
  wire        sts_push;
  wire        sts_ovr;
  wire        dfull;
  wire        store_ok;
  wire        d_ovr;
  wire [4:0]  first_dw;
  wire [10:0] keep_dw;
  wire [12:0] span;
  wire [12:0] rnd;
  wire [10:0] total_dw;
  wire [10:0] bsize;
  wire [15:0] bsum_new;
  wire        stop_done;
  wire        evt_clr_err;
  wire        evt_clr_stp;
  wire        err_set;
  wire [4:0]  used_rpt;
  wire [11:0] dfree;

  // ==========================================================
  // Bus phases; one wait state per transfer so read data is registered
  assign acc   = hsel_i & htrans_i[1] & hready_i;
  assign wr_go = ph_ff & ph_wr_ff;
  assign rd_go = ph_ff & ~ph_wr_ff;
  assign dwr   = wr_go & (ph_addr_ff == `ADDR_DATA);

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ph_ff      <= 1'b0;
      ph_wr_ff   <= 1'b0;
      ph_addr_ff <= 8'h00;
      hready_ff  <= 1'b1;
      hresp_ff   <= 1'b0;
    end else if (ph_ff) begin
      ph_ff     <= 1'b0;
      hready_ff <= 1'b1;
    end else if (acc) begin
      ph_ff      <= 1'b1;
      ph_wr_ff   <= hwrite_i;
      ph_addr_ff <= haddr_i[7:0];
      hready_ff  <= 1'b0;
    end
  end

  // ==========================================================
  // Submodules
  tx_status_compose u_compose (
    .ref_clk_i      (ref_clk_i),
    .resetn_i       (resetn_i),
    .done_i         (mac_done_i),
    .tag_i          (mac_tag_i),
    .lost_carrier_i (mac_lost_carrier_i),
    .no_carrier_i   (mac_no_carrier_i),
    .late_col_i     (mac_late_col_i),
    .excess_col_i   (mac_excess_col_i),
    .col_count_i    (mac_col_count_i),
    .excess_defer_i (mac_excess_defer_i),
    .deferred_i     (mac_deferred_i),
    .defchk_en_i    (cfg_defchk_ff),
    .word_o         (sts_word),
    .valid_o        (sts_valid)
  );

  tx_status_store u_store (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .clear_i     (purge_sts_ff),
    .push_i      (sts_push),
    .push_data_i (sts_word),
    .pop_i       (sts_pop),
    .head_o      (sts_head),
    .count_o     (sts_cnt),
    .full_o      (sts_full),
    .empty_o     (sts_empty)
  );

  // Status push; a lost word blocks pushes until the host reads
  assign sts_pop  = rd_go & (ph_addr_ff == `ADDR_STATUS) & ~sts_empty;
  assign sts_push = sts_valid & ~sts_full & ~sts_lost_ff;
  assign sts_ovr  = sts_valid & (sts_full | sts_lost_ff);
  assign used_rpt = sts_lost_ff ? 5'h00 : sts_cnt;

  // ==========================================================
  // Buffer geometry from the latched first command word
  assign bsize    = cmda_ff[`A_SIZE_HI:0];
  assign first_dw = {2'b00, cmda_ff[`A_OFS_HI:`A_OFS_LO+2]};
  assign keep_dw  = dw_ceil({2'b00, bsize} +
                    {11'h000, cmda_ff[`A_OFS_LO+1:`A_OFS_LO]});
  assign span     = {2'b00, bsize} + {8'h00, cmda_ff[`A_OFS_HI:`A_OFS_LO]};
  assign rnd      = (span + rmask) & ~rmask;
  assign total_dw = dw_ceil(rnd);
  assign bsum_new = bsum_ff + {5'h00, bsize};

  // End alignment of 4, 16 or 32 bytes
  always @* begin
    case (cmda_ff[`A_ALN_HI:`A_ALN_LO])
      2'b01:   rmask = 13'h000f;
      2'b10:   rmask = 13'h001f;
      default: rmask = 13'h0003;
    endcase
  end

  // Host data port sequencing: command A, command B, buffer words
  always @* begin
    nxt_dstate = dstate_ff;
    nxt_idx    = idx_ff;
    nxt_bsum   = bsum_ff;
    store_w    = 1'b0;
    b_err      = 1'b0;
    len_err    = 1'b0;
    pkt_done   = 1'b0;
    if (dwr) begin
      case (dstate_ff)
        D_CMDA: begin
          store_w    = 1'b1;
          nxt_dstate = D_CMDB;
        end
        D_CMDB: begin
          store_w = cmda_ff[`A_FS];
          b_err   = ~cmda_ff[`A_FS] & (hwdata_i != cmdb_ff);
          nxt_idx = 11'h000;
          nxt_dstate = D_DATA;
        end
        D_DATA: begin
          // Whole leading and trailing padding words are skipped
          store_w = ({6'h00, first_dw} <= idx_ff) &&
                    (idx_ff < ({6'h00, first_dw} + keep_dw));
          nxt_idx = idx_ff + 11'h001;
          if (nxt_idx >= total_dw) begin
            nxt_dstate = D_CMDA;
            nxt_bsum   = bsum_new;
            if (cmda_ff[`A_LS]) begin
              pkt_done = 1'b1;
              len_err  = bsum_new != {5'h00, cmdb_ff[`B_LEN_HI:0]};
              nxt_bsum = 16'h0000;
            end
          end
        end
        default: begin
          nxt_dstate = D_CMDA;
        end
      endcase
    end
  end

  // Data FIFO space accounting
  assign dfull    = (dused_ff == `TXD_CAP_DW);
  assign store_ok = store_w & ~dfull;
  assign d_ovr    = store_w & dfull;
  assign dfree    = `TXD_CAP_DW - dused_ff;

  always @(posedge ref_clk_i) begin
    if (!resetn_i || purge_dat_ff) begin
      dstate_ff <= D_CMDA;
      idx_ff    <= 11'h000;
      bsum_ff   <= 16'h0000;
      cmda_ff   <= 32'h0000_0000;
      cmdb_ff   <= 32'h0000_0000;
      dused_ff  <= 12'h000;
      pending_ff <= 8'h00;
    end else begin
      dstate_ff <= nxt_dstate;
      idx_ff    <= nxt_idx;
      bsum_ff   <= nxt_bsum;
      if (dwr && dstate_ff == D_CMDA) begin
        cmda_ff <= hwdata_i;
      end
      if (dwr && dstate_ff == D_CMDB && cmda_ff[`A_FS]) begin
        cmdb_ff <= hwdata_i;
      end
      // Drain below zero is ignored
      if (store_ok && !(mac_pop_i && dused_ff != 12'h000)) begin
        dused_ff <= dused_ff + 12'h001;
      end else if (!store_ok && mac_pop_i && dused_ff != 12'h000) begin
        dused_ff <= dused_ff - 12'h001;
      end
      if (pkt_done && !mac_start_i) begin
        pending_ff <= pending_ff + 8'h01;
      end else if (!pkt_done && mac_start_i && pending_ff != 8'h00) begin
        pending_ff <= pending_ff - 8'h01;
      end
    end
  end

  // Words forwarded to storage, registered
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      txd_wr_ff    <= 1'b0;
      txd_wdata_ff <= 32'h0000_0000;
    end else begin
      txd_wr_ff <= store_ok;
      if (store_ok) begin
        txd_wdata_ff <= hwdata_i;
      end
    end
  end

  // ==========================================================
  // Transmit gating and stop handshake
  assign stop_done = cfg_stop_ff &
                     (sts_valid | (~in_flight_ff & ~mac_start_i));

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      tx_go_ff      <= 1'b0;
      in_flight_ff  <= 1'b0;
      stop_pulse_ff <= 1'b0;
    end else begin
      // Full FIFO stalls new frames unless overrun is allowed
      tx_go_ff <= cfg_on_ff & ~cfg_stop_ff & (pending_ff != 8'h00) &
                  ~in_flight_ff & ~mac_start_i &
                  ~(sts_full & ~cfg_sao_ff);
      if (mac_start_i) begin
        in_flight_ff <= 1'b1;
      end else if (sts_valid) begin
        in_flight_ff <= 1'b0;
      end
      stop_pulse_ff <= stop_done;
    end
  end

  // ==========================================================
  // Registers; hardware stop clearing overrides a same-cycle write
  assign evt_clr_err = wr_go & (ph_addr_ff == `ADDR_EVT) &
                       hwdata_i[`EVT_TXERR];
  assign evt_clr_stp = wr_go & (ph_addr_ff == `ADDR_EVT) &
                       hwdata_i[`EVT_STOPPED];
  assign err_set = len_err | b_err | d_ovr |
                   (sts_ovr & ~cfg_sao_ff);

  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cfg_on_ff     <= |((`CFG_RESET >> `CFG_ON) & 4'h1);
      cfg_stop_ff   <= 1'b0;
      cfg_sao_ff    <= 1'b0;
      cfg_defchk_ff <= 1'b0;
      purge_sts_ff  <= 1'b0;
      purge_dat_ff  <= 1'b0;
      err_ff        <= 1'b0;
      stopped_ff    <= 1'b0;
      sts_lost_ff   <= 1'b0;
    end else begin
      purge_sts_ff <= 1'b0;
      purge_dat_ff <= 1'b0;
      if (wr_go && ph_addr_ff == `ADDR_CFG) begin
        cfg_on_ff     <= hwdata_i[`CFG_ON];
        cfg_stop_ff   <= hwdata_i[`CFG_STOP];
        cfg_sao_ff    <= hwdata_i[`CFG_SAO];
        cfg_defchk_ff <= hwdata_i[`CFG_DEFCHK];
        purge_sts_ff  <= hwdata_i[`CFG_PURGE_STS];
        purge_dat_ff  <= hwdata_i[`CFG_PURGE_DAT];
      end
      if (stop_done) begin
        cfg_on_ff   <= 1'b0;
        cfg_stop_ff <= 1'b0;
      end
      // Set wins over clear; error never halts the transmitter
      err_ff     <= (err_ff & ~evt_clr_err) | err_set;
      stopped_ff <= (stopped_ff & ~evt_clr_stp) | stop_done;
      if (sts_ovr && cfg_sao_ff) begin
        sts_lost_ff <= 1'b1;
      end else if (sts_pop || purge_sts_ff) begin
        sts_lost_ff <= 1'b0;
      end
    end
  end

  // Read data captured in the data phase
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_go) begin
      if (ph_addr_ff == `ADDR_STATUS) begin
        hrdata_ff <= sts_empty ? 32'h0000_0000 : sts_head;
      end else if (ph_addr_ff == `ADDR_CFG) begin
        hrdata_ff <= {28'h0000000, cfg_defchk_ff, cfg_sao_ff,
                      cfg_stop_ff, cfg_on_ff};
      end else if (ph_addr_ff == `ADDR_INF) begin
        hrdata_ff <= {11'h000, used_rpt, 4'h0, dfree};
      end else if (ph_addr_ff == `ADDR_EVT) begin
        hrdata_ff <= {30'h00000000, stopped_ff, err_ff};
      end else begin
        hrdata_ff <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign hrdata_o    = hrdata_ff;
  assign hreadyout_o = hready_ff;
  assign hresp_o     = hresp_ff;
  assign txd_wr_o    = txd_wr_ff;
  assign txd_wdata_o = txd_wdata_ff;
  assign tx_go_o     = tx_go_ff;
  assign transmit_stopped_event_o = stop_pulse_ff;
  assign transmit_error_flag_o    = err_ff;
endmodule // tx_status_fifo_and_control
`default_nettype wire

// file: hdl/tx_status_map.vh
// Register map, field positions and counts of the transmit status block
`ifndef TX_STATUS_MAP_VH
`define TX_STATUS_MAP_VH
// ==========================================================
// Register byte offsets
`define ADDR_DATA     8'h00
`define ADDR_STATUS   8'h04
`define ADDR_CFG      8'h08
`define ADDR_INF      8'h0c
`define ADDR_EVT      8'h10
// ==========================================================
// Configuration register fields
`define CFG_ON        0
`define CFG_STOP      1
`define CFG_SAO       2
`define CFG_DEFCHK    3
`define CFG_PURGE_STS 14
`define CFG_PURGE_DAT 15
`define CFG_RESET     4'h0
// Event register fields
`define EVT_TXERR     0
`define EVT_STOPPED   1
// ==========================================================
// First command word fields
`define A_FS          13
`define A_LS          12
`define A_OFS_HI      20
`define A_OFS_LO      16
`define A_ALN_HI      25
`define A_ALN_LO      24
`define A_SIZE_HI     10
// Second command word fields
`define B_TAG_LO      16
`define B_LEN_HI      10
// ==========================================================
// Status word fields
`define ST_ES         15
`define ST_LOC        11
`define ST_NOC        10
`define ST_LATE       9
`define ST_EXC        8
`define ST_CC_LO      3
`define ST_XDEF       2
`define ST_DEF        0
// ==========================================================
// Depths
`define STS_DEPTH     5'h10
`define TXD_CAP_DW    12'h400
`endif

// file: hdl/tx_status_store.v
// Status word FIFO with head visible for host reads
`default_nettype none
module tx_status_store (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        resetn_i,
  // Control
  input  wire        clear_i,
  input  wire        push_i,
  input  wire [31:0] push_data_i,
  input  wire        pop_i,
  // State
  output wire [31:0] head_o,
  output wire [4:0]  count_o,
  output wire        full_o,
  output wire        empty_o
);
`include "tx_status_map.vh"
  reg [31:0] mem [0:15];
  reg [3:0]  wr_ptr_ff;
  reg [3:0]  rd_ptr_ff;
  reg [4:0]  cnt_ff;
  wire       do_push;
  wire       do_pop;

  // Guard against push when full and pop when empty
  assign do_push = push_i & (cnt_ff != `STS_DEPTH);
  assign do_pop  = pop_i & (cnt_ff != 5'h00);
  assign head_o  = mem[rd_ptr_ff];
  assign count_o = cnt_ff;
  assign full_o  = (cnt_ff == `STS_DEPTH);
  assign empty_o = (cnt_ff == 5'h00);

  // Storage has no reset; only pointers matter
  always @(posedge ref_clk_i) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= push_data_i;
    end
  end

  // Pointers and fill count
  always @(posedge ref_clk_i) begin
    if (!resetn_i || clear_i) begin
      wr_ptr_ff <= 4'h0;
      rd_ptr_ff <= 4'h0;
      cnt_ff    <= 5'h00;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= wr_ptr_ff + 4'h1;
      end
      if (do_pop) begin
        rd_ptr_ff <= rd_ptr_ff + 4'h1;
      end
      if (do_push && !do_pop) begin
        cnt_ff <= cnt_ff + 5'h01;
      end else if (do_pop && !do_push) begin
        cnt_ff <= cnt_ff - 5'h01;
      end
    end
  end
endmodule // tx_status_store
`default_nettype wire

// file: tb/mac_model.sv
// Transmitter model that takes packets and reports frame results
`default_nettype none
module mac_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // Handshake
  input  wire logic       tx_go_i,
  output var  logic       start_o,
  output var  logic       pop_o,
  output var  logic       done_o,
  output var  logic [9:0] res_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 4886;
  // ==========================================================
  // One frame at a time, prompt or slow; stale results inverted
  initial begin
    start_o = 0;
    pop_o = 0;
    done_o = 0;
    res_o = '0;
    forever begin
      @(posedge ref_clk_i);
      if (resetn_i && tx_go_i) begin
        start_o <= 1;
        @(posedge ref_clk_i);
        start_o <= 0;
        pop_o <= 1;
        @(posedge ref_clk_i);
        pop_o <= 0;
        repeat ($unsigned($random(seed)) % 6) @(posedge ref_clk_i);
        done_o <= 1;
        res_o <= $random(seed);
        @(posedge ref_clk_i);
        done_o <= 0;
        res_o <= ~res_o;
      end
    end
  end
endmodule // mac_model
`default_nettype wire

// file: tb/tx_status_fifo_and_control_tb.sv
// Self-checking bench of the transmit status and control block
`default_nettype none
module tx_status_fifo_and_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i, resetn_i, hsel, hwrite, hready, hresp;
  logic        txd_wr, go, stopped, txerr, start, pop, done;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, txd_wdata;
  logic [9:0]  res;
  logic [15:0] cur_tag;
  logic [31:0] expq[$], wq[$];
  logic [15:0] tagq[$];
  int          errors, comparisons, nwr, nst, nstop, dchk, s0;
  int          seed = 4886;
  // ==========================================================
  // Design and transmitter model
  tx_status_fifo_and_control i_dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .txd_wr_o(txd_wr), .txd_wdata_o(txd_wdata), .tx_go_o(go),
    .mac_start_i(start), .mac_pop_i(pop), .mac_done_i(done),
    .mac_tag_i(cur_tag), .mac_lost_carrier_i(res[0]),
    .mac_no_carrier_i(res[1]), .mac_late_col_i(res[2]),
    .mac_excess_col_i(res[3]), .mac_col_count_i(res[7:4]),
    .mac_excess_defer_i(res[8]), .mac_deferred_i(res[9]),
    .transmit_stopped_event_o(stopped), .transmit_error_flag_o(txerr));
  mac_model i_mac (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .tx_go_i(go), .start_o(start), .pop_o(pop), .done_o(done),
    .res_o(res));
  // ==========================================================
  // Expected status word; count field left zero when unreliable
  function automatic logic [31:0] exp_st(logic [15:0] t, logic [9:0] r,
                                         logic dc);
    logic xd;
    xd = r[8] & dc;
    exp_st = {t, |{r[3:0], xd}, 3'h0, r[0], r[1], r[2], r[3], 1'b0,
              r[3] ? 4'h0 : r[7:4], xd, 1'b0, r[9]};
  endfunction
  // Event counters; tag follows the packet the transmitter took
  always @(posedge ref_clk_i) begin
    if (txd_wr === 1'b1) begin
      nwr++;
      wq.push_back(txd_wdata);
    end
    if (stopped === 1'b1) nstop++;
    if (start === 1'b1) begin
      nst++;
      cur_tag <= tagq.pop_front();
    end
    if (done === 1'b1) expq.push_back(exp_st(cur_tag, res, dchk[0]));
  end
  // ==========================================================
  // Verdict, comparison and bus tasks
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Address phase held until hready, then data phase until hready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    n = 0;
    do begin @(posedge ref_clk_i); n++; end while (hready !== 1'b1 && n < 99);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge ref_clk_i); n++; end while (hready !== 1'b1 && n < 99);
    rd = hrdata;
    if (n >= 99) begin
      errors++;
      tally_and_finish;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, m);
    xfer(0, a, 32'h0);
    check(rd & m, e);
  endtask
  // Bounded wait for the transmitter to take k packets in all
  task automatic wst(input int k);
    int n;
    for (n = 0; n < 3000 && nst < k; n++) @(posedge ref_clk_i);
    if (nst < k) begin
      errors++;
      tally_and_finish;
    end
    repeat (14) @(posedge ref_clk_i);
  endtask
  // Pop one status word; collision count masked when unreliable
  task automatic rst_chk;
    logic [31:0] e;
    e = expq.pop_front();
    xfer(0, 8'h04, 32'h0);
    check(rd & (e[8] ? ~32'h78 : ~32'h0), e);
  endtask
  // One buffer, first/last flags in fl, 16-byte end alignment
  task automatic send(input int off, input int sz, input int ln,
                      input logic [1:0] fl = 2'h3);
    logic [15:0] t;
    logic [31:0] a;
    int n0, nw;
    t = $random(seed);
    if (fl[1]) tagq.push_back(t);
    n0 = nwr;
    a = {6'h0, 2'h1, 3'h0, off[4:0], 2'h0, fl, 1'b0, sz[10:0]};
    xfer(1, 8'h00, a);
    xfer(1, 8'h00, {t, 5'h0, ln[10:0]});
    nw = (off + sz + 15) / 16 * 4;
    repeat (nw) xfer(1, 8'h00, $random(seed));
    repeat (3) @(posedge ref_clk_i);
    check(nwr - n0, 1 + fl[1] + (off % 4 + sz + 3) / 4);
    check(wq[n0], a);
    if (fl[1]) check(wq[n0 + 1], {t, 5'h0, ln[10:0]});
  endtask
  // ==========================================================
  // Clock, reset and scenarios
  initial begin
    ref_clk_i = 0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    resetn_i = 0; hsel = 0; htrans = 0; hwrite = 0; haddr = 0;
    hwdata = 0; cur_tag = 0; dchk = 0;
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1;
    @(posedge ref_clk_i);
    rchk(8'h08, 32'h0, ~32'h0);
    rchk(8'h0c, 32'h400, ~32'h0);
    rchk(8'h14, 32'h0, ~32'h0);
    $display("test reset done");
    // Random packets, deferral check toggled, status per packet
    for (int i = 0; i < 8; i++) begin
      dchk = i % 2;
      xfer(1, 8'h08, 32'h1 | (dchk << 3));
      send($unsigned($random(seed)) % 32, 1 + $unsigned($random(seed)) % 40,
           -1);
      wst(i + 1);
      rst_chk;
    end
    $display("test status words done");
    // Length field wrong: error flagged, frame still sent
    check(txerr, 1'b1);
    rchk(8'h10, 32'h1, 32'h1);
    xfer(1, 8'h10, 32'h1);
    rchk(8'h10, 32'h0, 32'h1);
    send(4, 8, 9);
    wst(9);
    rst_chk;
    rchk(8'h10, 32'h1, 32'h1);
    xfer(1, 8'h10, 32'h1);
    $display("test length error done");
    // Full status FIFO holds transmission until one word is read
    for (int i = 0; i < 17; i++) send(0, 4, 4);
    wst(25);
    repeat (60) @(posedge ref_clk_i);
    check(nst, 25);
    rchk(8'h0c, 32'h100000, 32'h1f0000);
    rst_chk;
    wst(26);
    // Overrun mode: sent anyway, word lost, used reads zero, no error
    dchk = 0;
    xfer(1, 8'h08, 32'h5);
    send(0, 4, 4);
    wst(27);
    void'(expq.pop_back());
    rchk(8'h0c, 32'h0, 32'h1f0000);
    rchk(8'h10, 32'h0, 32'h1);
    for (int i = 0; i < 16; i++) rst_chk;
    $display("test full status done");
    // Stop while idle, packet held, enable restarts it
    s0 = nstop;
    xfer(1, 8'h08, 32'h3);
    repeat (4) @(posedge ref_clk_i);
    rchk(8'h08, 32'h0, 32'h3);
    check(nstop - s0, 1);
    send(1, 6, 6);
    repeat (40) @(posedge ref_clk_i);
    check(nst, 27);
    xfer(1, 8'h08, 32'h1);
    wst(28);
    rst_chk;
    $display("test stop restart done");
    // Two buffers of one packet whose second command words differ
    send(0, 4, 8, 2'h2);
    rchk(8'h10, 32'h0, 32'h1);
    send(0, 4, 8, 2'h1);
    rchk(8'h10, 32'h1, 32'h1);
    wst(29);
    rst_chk;
    $display("test command mismatch done");
    tally_and_finish;
  end
endmodule // tx_status_fifo_and_control_tb
bind tx_status_fifo_and_control tx_status_monitor i_mon (.ref_clk_i,
  .resetn_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
  .hreadyout_o, .hresp_o, .tx_go_o, .mac_start_i, .mac_done_i,
  .transmit_stopped_event_o);
`default_nettype wire

// file: tb/tx_status_monitor.sv
// Checker of bus timing and transmit control outputs
`default_nettype none
module tx_status_monitor (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  // Bus
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // Transmit control
  input wire logic        tx_go_o,
  input wire logic        mac_start_i,
  input wire logic        mac_done_i,
  input wire logic        transmit_stopped_event_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Relations between requests and answers
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  wire tk = hsel_i & htrans_i[1] & hready_i;
  one_wait_a: assert property (tk |=> !hreadyout_o ##1 hreadyout_o)
    else $error("bus wait is not one cycle");
  lone_wait_a: assert property (!hreadyout_o |-> $past(tk))
    else $error("wait state without a request");
  resp_okay_a: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  wr_hold_a: assert property (tk && hwrite_i |=> ##1 $stable(hrdata_o))
    else $error("read data moved on a write");
  // Reset is checked with no disable, it is its own cause
  reset_idle_a: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    !resetn_i |=> hreadyout_o && !tx_go_o)
    else $error("outputs not idle after reset");
  go_drop_a: assert property (mac_start_i |=> !tx_go_o)
    else $error("start allowed while a frame is in flight");
  done_nogo_a: assert property (mac_done_i |-> !tx_go_o)
    else $error("start allowed before status word");
  stop_pulse_a: assert property (transmit_stopped_event_o |=>
    !transmit_stopped_event_o)
    else $error("stopped event longer than one cycle");
  stop_nogo_a: assert property (transmit_stopped_event_o |-> !tx_go_o)
    else $error("start allowed while stopping");
endmodule // tx_status_monitor
`default_nettype wire
